// ===== dv/dmapc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module dmapc_bus_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pace knob
  input wire logic slow,
  // bus handshake
  input wire logic busReqValid,
  output logic busAck,
  output logic busDone
);
  // one transaction at a time: ack, then end pulse; slow stretches both
  initial begin
    busAck = 1'b0;
    busDone = 1'b0;
    forever begin
      @(posedge mclk);
      if (nrst && busReqValid) begin
        repeat (slow ? 3 : 0) @(posedge mclk);
        busAck <= 1'b1;
        @(posedge mclk);
        busAck <= 1'b0;
        repeat (slow ? 4 : 1) @(posedge mclk);
        busDone <= 1'b1;
        @(posedge mclk);
        busDone <= 1'b0;
      end
    end
  end
endmodule : dmapc_bus_model

`default_nettype wire

// ===== dv/dmapc_top_chk.sv
`timescale 1ns/1ps
`include "dmapc_cfg.svh"
`default_nettype none

module dmapc_top_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [`DMAPC_AW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // bus side
  input wire logic busReqValid,
  input wire dmapc_pkg::dmapc_busreq_t busReq,
  input wire logic busAck,
  input wire logic busDone,
  // events and interrupts
  input wire logic errEvent,
  input wire logic chainDoneEvent,
  input wire logic xferDoneEvent,
  input wire logic errIrq,
  input wire logic chainIrq,
  input wire logic xferIrq
);
  import dmapc_pkg::*;
  logic [31:0] cfg_ff;
  logic [10:0] gap_ff;
  logic [10:0] need_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // shadow of the config register, rebuilt from writes only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= 32'h0;
    end else if (regWr && regAddr == `DMAPC_CFG_OFS) begin
      cfg_ff <= regWrData & 32'h00083f00;
    end
  end

  // clocks since a transaction ended; the needed gap is latched then, so
  // a later spacing write cannot move the goalposts
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gap_ff <= 11'h7ff;
      need_ff <= 11'h0;
    end else if (busDone) begin
      gap_ff <= 11'h0;
      need_ff <= (cfg_ff[13:11] == 3'h0) ? 11'h0 : 11'h8 << cfg_ff[13:11];
    end else if (gap_ff != 11'h7ff) begin
      gap_ff <= gap_ff + 11'h1;
    end
  end

  a_rd_config: assert property (regRd && regAddr == `DMAPC_CFG_OFS |=> regRdData == cfg_ff)
    else $error("config read differs");
  a_err_gate: assert property (errIrq == ($past(errEvent) && $past(cfg_ff[10])))
    else $error("error irq wrong");
  a_chain_gate: assert property (chainIrq == ($past(chainDoneEvent) && $past(cfg_ff[9])))
    else $error("chain irq wrong");
  a_xfer_gate: assert property (xferIrq == ($past(xferDoneEvent) && $past(cfg_ff[8])))
    else $error("transfer irq wrong");
  a_burst_block: assert property (busReqValid && busReq.burst |-> busReq.chain || !cfg_ff[19])
    else $error("burst while blocked");
  a_beat_shape: assert property (busReqValid |-> busReq.beats == (busReq.burst ? 5'h10 : 5'h01))
    else $error("beat count wrong");
  a_req_hold: assert property (busReqValid && !busAck |=> busReqValid && $stable(busReq))
    else $error("request moved before ack");
  a_ack_release: assert property (busReqValid && busAck |=> !busReqValid)
    else $error("request held after ack");
  a_gap_kept: assert property ($rose(busReqValid) |-> gap_ff >= need_ff)
    else $error("request spacing too short");

  c_burst: cover property (busReqValid && busAck && busReq.burst);
  c_long_gap: cover property ($rose(busReqValid) && need_ff == 11'h400);
  c_all_irq: cover property (errIrq && chainIrq && xferIrq);
endmodule : dmapc_top_chk

bind dmapc_top dmapc_top_chk u_chk (.mclk, .nrst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .busReqValid, .busReq, .busAck, .busDone, .errEvent, .chainDoneEvent,
  .xferDoneEvent, .errIrq, .chainIrq, .xferIrq);

`default_nettype wire

// ===== dv/tb_dmapc_top.sv
`timescale 1ns/1ps
`include "dmapc_cfg.svh"
`default_nettype none

module tb_dmapc_top;
  import dmapc_pkg::*;
  logic mclk, nrst, regWr, regRd, cmdValid, cmdReady, busReqValid, busAck, busDone, slow;
  logic errEvent, chainDoneEvent, xferDoneEvent, errIrq, chainIrq, xferIrq, rdD, evD;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  dmapc_cmd_t cmdIn;
  dmapc_busreq_t busReq;
  logic [38:0] rdQ[$], reqQ[$], irqQ[$];
  int n_errors, compares, cyc;

  dmapc_top dut (.mclk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .cmdValid,
    .cmdIn, .cmdReady, .busReqValid, .busReq, .busAck, .busDone, .errEvent, .chainDoneEvent,
    .xferDoneEvent, .errIrq, .chainIrq, .xferIrq);
  dmapc_bus_model u_bus (.mclk, .nrst, .slow, .busReqValid, .busAck, .busDone);

  always #5 mclk = ~mclk;

  task automatic finish_test;
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [38:0] s, input logic [38:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  // one register cycle: op[0] write, op[1] read, 0 idle; v is the expected read
  task automatic op(input logic [1:0] o, input logic [7:0] a, input logic [31:0] v);
    regWr <= o[0];
    regRd <= o[1];
    regAddr <= a;
    regWrData <= v;
    if (o[1]) rdQ.push_back(v);
    @(posedge mclk);
  endtask : op

  // expected split: whole aligned 16-word bursts where allowed, singles otherwise
  function automatic void plan(input logic [31:0] a, input int n, input logic ch, wb, bb);
    while (n > 0) begin
      if (wb && a[5:2] == 4'h0 && n >= 16 && (ch || !bb)) begin
        reqQ.push_back({a, 5'h10, 1'b1, ch});
        a += 64;
        n -= 16;
      end else begin
        reqQ.push_back({a, 5'h01, 1'b0, ch});
        a += 4;
        n -= 1;
      end
    end
  endfunction : plan

  // valid is left high so back-to-back commands need no gap
  task automatic send(input logic [31:0] a, input logic [4:0] n, input logic ch, wb, bb);
    plan(a, n, ch, wb, bb);
    cmdIn <= {a, n, ch, wb};
    cmdValid <= 1'b1;
    do @(posedge mclk); while (cmdReady !== 1'b1);
  endtask : send

  task automatic drain;
    while (reqQ.size() != 0) @(posedge mclk);
    repeat (8) @(posedge mclk);
  endtask : drain

  // results are matched against the oldest note as they appear
  always @(posedge mclk) begin
    rdD <= regRd;
    evD <= errEvent | chainDoneEvent | xferDoneEvent;
    if (rdD) chk(regRdData, rdQ.pop_front());
    if (evD) chk({errIrq, chainIrq, xferIrq}, irqQ.pop_front());
    if (busReqValid && busAck) chk(busReq, reqQ.pop_front());
    if (++cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {mclk, nrst, regWr, regRd, cmdValid, slow} = 6'h00;
    {errEvent, chainDoneEvent, xferDoneEvent} = 3'h0;
    {regAddr, regWrData, cmdIn} = '0;
    n_errors = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(36055));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    // reset value, then an unmapped place that ignores writes
    op(2'b10, `DMAPC_CFG_OFS, 32'h0);
    op(2'b01, 8'h20, 32'hffffffff);
    op(2'b10, 8'h20, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      op(2'b01, `DMAPC_CFG_OFS, d);
      op(2'b10, `DMAPC_CFG_OFS, d & 32'h00083f00);
    end
    // every enable mask against random event mixes
    for (int e = 0; e < 8; e++) begin
      d = $urandom;
      op(2'b01, `DMAPC_CFG_OFS, e << 8);
      op(2'b00, 8'h0, 32'h0);
      {errEvent, chainDoneEvent, xferDoneEvent} <= d[2:0];
      if (d[2:0] != 3'h0) irqQ.push_back(d[2:0] & e[2:0]);
      @(posedge mclk);
      {errEvent, chainDoneEvent, xferDoneEvent} <= 3'h0;
      @(posedge mclk);
    end
    // block, chain, alignment and burst request in all mixes
    for (int k = 0; k < 16; k++) begin
      op(2'b01, `DMAPC_CFG_OFS, {12'h0, k[0], 19'h0});
      op(2'b00, 8'h0, 32'h0);
      send(k[2] ? 32'h1004 : 32'h1000, 5'h10, k[1], k[3], k[0]);
      send(32'h2000 + ($urandom & 32'hfc), 5'($urandom_range(16, 1)), k[1], 1'b1, k[0]);
      cmdValid <= 1'b0;
      drain();
      // status is read-only and shows an idle, empty, expired channel here
      op(2'b01, `DMAPC_STAT_OFS, 32'hffffffff);
      op(2'b10, `DMAPC_STAT_OFS, 32'h0);
    end
    // every spacing code; a slow bus lets three commands fill the buffer
    for (int c = 0; c < 8; c++) begin
      slow <= c[0];
      op(2'b01, `DMAPC_CFG_OFS, c << 11);
      op(2'b00, 8'h0, 32'h0);
      repeat (3) send(32'h3000, 5'h02, 1'b0, 1'b0, 1'b0);
      cmdValid <= 1'b0;
      drain();
    end
    finish_test();
  end
endmodule : tb_dmapc_top

`default_nettype wire

// ===== logic/dmapc_buf.sv
`timescale 1ns/1ps
`default_nettype none

module dmapc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // filling side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic notFull_ff;
  logic notEmpty_ff;
  logic push;
  logic pop;

  assign push = inValid & notFull_ff;
  assign pop = notEmpty_ff & outReady;
  assign inReady = notFull_ff;
  assign outValid = notEmpty_ff;
  assign outData = mem_ff[rp_ff];

  // occupancy; full and empty are kept as flops so ready never glitches
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      notFull_ff <= 1'b1;
      notEmpty_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      notFull_ff <= (nxt_cnt != CW'(DEPTH));
      notEmpty_ff <= (nxt_cnt != '0);
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + PW'(1);
      end
      if (pop) begin
        rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + PW'(1);
      end
    end
  end

  // storage carries no reset; empty slots are never read out as valid
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wp_ff] <= inData;
    end
  end

endmodule : dmapc_buf

`default_nettype wire

// ===== logic/dmapc_cfg.svh
`ifndef DMAPC_CFG_SVH
`define DMAPC_CFG_SVH

// register port
`define DMAPC_AW 8
`define DMAPC_CFG_OFS 8'h10
`define DMAPC_STAT_OFS 8'h14

// config register field positions
`define DMAPC_BURST_BLOCK_BIT 19
`define DMAPC_SPACING_LSB 11
`define DMAPC_SPACING_MSB 13
`define DMAPC_ERR_IE_BIT 10
`define DMAPC_CHAIN_IE_BIT 9
`define DMAPC_XFER_IE_BIT 8

// config register reset values
`define DMAPC_SPACING_RST 3'h0
`define DMAPC_BIT_RST 1'b0

// status register field positions
`define DMAPC_STAT_STATE_LSB 0
`define DMAPC_STAT_GAP_BIT 2
`define DMAPC_STAT_BUF_BIT 3
`define DMAPC_STAT_LEFT_LSB 8
`define DMAPC_STAT_GAPCNT_LSB 16

// timing and burst shape
`define DMAPC_GAP_BASE 16
`define DMAPC_BURST_BEATS 5'h10
`define DMAPC_SINGLE_BEATS 5'h01

`endif

// ===== logic/dmapc_gap.sv
`timescale 1ns/1ps
`include "dmapc_cfg.svh"
`default_nettype none

module dmapc_gap #(
  parameter int CW = 11
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic [2:0] code,
  // state
  output logic expired,
  output logic [CW-1:0] count
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] interval;

  // code 0 loads nothing, so the next request may follow at once
  assign interval = (code == 3'h0) ? '0 :
    (CW'(`DMAPC_GAP_BASE) << (code - 3'h1));
  assign expired = (cnt_ff == '0);
  assign count = cnt_ff;

  // loaded at the end of a transaction, then counts down once per clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= interval;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

endmodule : dmapc_gap

`default_nettype wire

// ===== logic/dmapc_pkg.sv
package dmapc_pkg;

  // one command from the channel core: a data move or a chain operation
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] words;
    logic chain;
    logic wantBurst;
  } dmapc_cmd_t;

  // one transaction handed to the internal bus
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] beats;
    logic burst;
    logic chain;
  } dmapc_busreq_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_REQ = 2'b10,
    ST_BUSY = 2'b11
  } dmapc_state_t;

endpackage : dmapc_pkg

// ===== logic/dmapc_top.sv
// How it works
// - burst-block set: data transfers go out as singles even if bursts are asked
// - burst-block leaves descriptor fetches and chain operations untouched
// - block clear: burst when programmed, aligned and enough words remain, else single
// - successive bus transactions are kept apart by the chosen spacing
// - spacing 000 is back-to-back; 001..111 give 16 to 1024 bus clocks
// - error interrupt only when the error enable bit is one
// - chain-done interrupt only when the chain-done enable bit is one
// - transfer-done interrupt only when the transfer-done enable bit is one
// - spacing, burst-block and enables reset to zero and are read/write
`timescale 1ns/1ps
`include "dmapc_cfg.svh"
`default_nettype none

module dmapc_top #(
  parameter int BUF_DEPTH = 2,
  parameter int GAP_W = 11
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [`DMAPC_AW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // commands from the channel core
  input wire logic cmdValid,
  input wire dmapc_pkg::dmapc_cmd_t cmdIn,
  output logic cmdReady,
  // internal bus request side
  output logic busReqValid,
  output dmapc_pkg::dmapc_busreq_t busReq,
  input wire logic busAck,
  input wire logic busDone,
  // channel events
  input wire logic errEvent,
  input wire logic chainDoneEvent,
  input wire logic xferDoneEvent,
  // interrupt requests
  output logic errIrq,
  output logic chainIrq,
  output logic xferIrq
);

  import dmapc_pkg::*;

  localparam int CMD_W = $bits(dmapc_cmd_t);

  // configuration fields
  logic burstBlock_ff;
  logic [2:0] spacing_ff;
  logic error_irq_enable_ff;
  logic chainIe_ff;
  logic xferIe_ff;

  // register port
  logic [31:0] rdData_ff;
  logic [31:0] cfgWord;
  logic [31:0] statWord;
  logic cfgHit;
  logic statHit;

  // command buffer
  logic bufValid;
  logic bufReady;
  logic [CMD_W-1:0] bufData;
  dmapc_cmd_t bufCmd;

  // transaction sequencer
  dmapc_state_t state_ff;
  dmapc_state_t nxt_state;
  logic [31:0] addr_ff;
  logic [4:0] left_ff;
  logic chain_ff;
  logic wantBurst_ff;
  logic reqValid_ff;
  dmapc_busreq_t req_ff;
  dmapc_busreq_t nxt_req;
  logic aligned;
  logic enough;
  logic doBurst;
  logic issue;
  logic endTxn;

  // spacing timer
  logic gapExpired;
  logic [GAP_W-1:0] gapCount;

  // interrupt pulses
  logic errIrq_ff;
  logic chainIrq_ff;
  logic xferIrq_ff;

  assign regRdData = rdData_ff;
  assign busReqValid = reqValid_ff;
  assign busReq = req_ff;
  assign errIrq = errIrq_ff;
  assign chainIrq = chainIrq_ff;
  assign xferIrq = xferIrq_ff;

  // ---------------------------------------------------------------
  // register decode
  assign cfgHit = (regAddr == `DMAPC_CFG_OFS);
  assign statHit = (regAddr == `DMAPC_STAT_OFS);

  // config fields hold their value until software rewrites them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      burstBlock_ff <= `DMAPC_BIT_RST;
      spacing_ff <= `DMAPC_SPACING_RST;
      error_irq_enable_ff <= `DMAPC_BIT_RST;
      chainIe_ff <= `DMAPC_BIT_RST;
      xferIe_ff <= `DMAPC_BIT_RST;
    end else if (regWr && cfgHit) begin
      burstBlock_ff <= regWrData[`DMAPC_BURST_BLOCK_BIT];
      spacing_ff <= regWrData[`DMAPC_SPACING_MSB:`DMAPC_SPACING_LSB];
      error_irq_enable_ff <= regWrData[`DMAPC_ERR_IE_BIT];
      chainIe_ff <= regWrData[`DMAPC_CHAIN_IE_BIT];
      xferIe_ff <= regWrData[`DMAPC_XFER_IE_BIT];
    end
  end

  // reserved bits of both words read as zero
  always_comb begin
    cfgWord = 32'h0000_0000;
    cfgWord[`DMAPC_BURST_BLOCK_BIT] = burstBlock_ff;
    cfgWord[`DMAPC_SPACING_MSB:`DMAPC_SPACING_LSB] = spacing_ff;
    cfgWord[`DMAPC_ERR_IE_BIT] = error_irq_enable_ff;
    cfgWord[`DMAPC_CHAIN_IE_BIT] = chainIe_ff;
    cfgWord[`DMAPC_XFER_IE_BIT] = xferIe_ff;
  end

  // status shows the sequencer, the timer and the buffer
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[`DMAPC_STAT_STATE_LSB +: 2] = state_ff;
    statWord[`DMAPC_STAT_GAP_BIT] = ~gapExpired;
    statWord[`DMAPC_STAT_BUF_BIT] = bufValid;
    statWord[`DMAPC_STAT_LEFT_LSB +: 5] = left_ff;
    statWord[`DMAPC_STAT_GAPCNT_LSB +: GAP_W] = gapCount;
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (regRd && cfgHit) begin
      rdData_ff <= cfgWord;
    end else if (regRd && statHit) begin
      rdData_ff <= statWord;
    end else begin
      rdData_ff <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // two-entry buffer between the channel core and the sequencer;
  // a busy bus stalls the sequencer, the buffer fills and cmdReady drops
  dmapc_buf #(
    .W(CMD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .inValid(cmdValid),
    .inData(cmdIn),
    .inReady(cmdReady),
    .outValid(bufValid),
    .outData(bufData),
    .outReady(bufReady)
  );

  assign bufCmd = dmapc_cmd_t'(bufData);
  assign bufReady = (state_ff == ST_IDLE);

  // ---------------------------------------------------------------
  // spacing timer, restarted at the end of every bus transaction
  dmapc_gap #(
    .CW(GAP_W)
  ) u_gap (
    .mclk(mclk),
    .nrst(nrst),
    .start(endTxn),
    .code(spacing_ff),
    .expired(gapExpired),
    .count(gapCount)
  );

  // ---------------------------------------------------------------
  // burst choice for the next transaction, from the current address and
  // the words still to move; a short tail always falls back to singles
  assign aligned = (addr_ff[5:2] == 4'h0);
  assign enough = (left_ff >= `DMAPC_BURST_BEATS);

  always_comb begin
    if (chain_ff) begin
      doBurst = wantBurst_ff & aligned & enough;
    end else begin
      doBurst = wantBurst_ff & ~burstBlock_ff & aligned & enough;
    end
  end

  always_comb begin
    nxt_req.addr = addr_ff;
    nxt_req.burst = doBurst;
    nxt_req.beats = doBurst ? `DMAPC_BURST_BEATS : `DMAPC_SINGLE_BEATS;
    nxt_req.chain = chain_ff;
  end

  // a request goes out only once the spacing has run down
  assign issue = (state_ff == ST_WAIT) && gapExpired;
  assign endTxn = (state_ff == ST_BUSY) && busDone;

  // sequencer: take a command, then one bus transaction per pass
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (bufValid) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (issue) begin
          nxt_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (busAck) begin
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (busDone) begin
          nxt_state = (left_ff <= req_ff.beats) ? ST_IDLE : ST_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // command under work: address and words left advance per transaction
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= 32'h0000_0000;
      left_ff <= 5'h00;
      chain_ff <= 1'b0;
      wantBurst_ff <= 1'b0;
    end else if (bufValid && bufReady) begin
      addr_ff <= bufCmd.addr;
      left_ff <= bufCmd.words;
      chain_ff <= bufCmd.chain;
      wantBurst_ff <= bufCmd.wantBurst;
    end else if (endTxn) begin
      addr_ff <= addr_ff + {25'h0000000, req_ff.beats, 2'h0};
      left_ff <= (left_ff <= req_ff.beats) ? 5'h00 : left_ff - req_ff.beats;
    end
  end

  // request held steady until the bus accepts it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reqValid_ff <= 1'b0;
      req_ff <= '0;
    end else if (issue) begin
      reqValid_ff <= 1'b1;
      req_ff <= nxt_req;
    end else if (state_ff == ST_REQ && busAck) begin
      reqValid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests: one-cycle pulses, each gated by its enable;
  // the core above keeps its own sticky status
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      errIrq_ff <= 1'b0;
      chainIrq_ff <= 1'b0;
      xferIrq_ff <= 1'b0;
    end else begin
      errIrq_ff <= errEvent & error_irq_enable_ff;
      chainIrq_ff <= chainDoneEvent & chainIe_ff;
      xferIrq_ff <= xferDoneEvent & xferIe_ff;
    end
  end

endmodule : dmapc_top

`default_nettype wire
